/* File: ppc_port_rate_link.sv */
`timescale 1ns/10ps
`default_nettype none
module ppc_port_rate_link
    import ppc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Register access from the management interface
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Strap
    input wire logic duplex_strap_pin,
    // Negotiation results per port
    input wire logic [NPORTS-1:0] an_failed,
    input wire logic [NPORTS-1:0] an_speed_100,
    input wire logic [NPORTS-1:0] an_full,
    // Rate limit counts per port
    input wire logic [NPORTS-1:0][RATE_W-1:0] hi_cnt,
    input wire logic [NPORTS-1:0][RATE_W-1:0] lo_cnt,
    // Rate controls per port
    output logic [NPORTS-1:0] rx_hi_fc_en,
    output logic [NPORTS-1:0] rx_all_lo,
    output logic [NPORTS-1:0] tx_hi_en,
    output logic [NPORTS-1:0] tx_lo_en,
    output logic [NPORTS-1:0][RATE_W-1:0] tx_hi_rate,
    output logic [NPORTS-1:0][RATE_W-1:0] tx_lo_rate,
    // Link controls per port
    output logic [NPORTS-1:0] an_enable,
    output logic [NPORTS-1:0] speed_100,
    output logic [NPORTS-1:0] full_duplex,
    output logic [NPORTS-1:0] adv_fc
);
    typedef struct packed {
        logic [NPORTS-1:0][7:0] rate;
        logic [NPORTS-1:0][7:0] link;
        logic [7:0] rdata;
        logic rvalid;
        logic strap_s1;
        logic strap_s2;
        logic [1:0] settle;
        logic strap_done;
    } ppc_bank_st_t;

    ppc_bank_st_t st_q;
    ppc_bank_st_t st_d;

    ppc_cfg_if cfg_if[NPORTS]();

    // Register bank: each register written only by its own address, except the strap load into the duplex bit of STRAP_PORT
    always_comb
    begin
        st_d = st_q;
        st_d.rvalid = reg_rd;
        st_d.rdata = UNMAPPED_RD;
        // Strap passes two flops before use
        st_d.strap_s1 = duplex_strap_pin;
        st_d.strap_s2 = st_q.strap_s1;
        if (st_q.settle != STRAP_SETTLE)
        begin
            st_d.settle = st_q.settle + 2'h1;
        end
        for (int p = 0; p < NPORTS; p++)
        begin
            if (reg_wr && reg_addr == RATE_OFS[p])
            begin
                st_d.rate[p] = reg_wdata;
            end
            else if (reg_wr && reg_addr == LINK_OFS[p])
            begin
                st_d.link[p] = reg_wdata;
            end
            if (reg_rd && reg_addr == RATE_OFS[p])
            begin
                st_d.rdata = st_q.rate[p];
            end
            else if (reg_rd && reg_addr == LINK_OFS[p])
            begin
                st_d.rdata = st_q.link[p];
            end
        end
        // Load the strap once it has settled; it overrides the duplex bit of a
        // software write in that same cycle, since the strap defines the reset value
        if (!st_q.strap_done && st_q.settle == STRAP_SETTLE)
        begin
            st_d.link[STRAP_PORT][DUPLEX_BIT] = st_q.strap_s2;
            st_d.strap_done = 1'b1;
        end
        if (srst)
        begin
            st_d = '0;
            for (int p = 0; p < NPORTS; p++)
            begin
                st_d.rate[p] = RATE_RST;
                st_d.link[p] = LINK_RST;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        st_q <= st_d;
    end

    assign reg_rdata = st_q.rdata;
    assign reg_rvalid = st_q.rvalid;

    // One decoder per port
    for (genvar g = 0; g < NPORTS; g++)
    begin : g_port
        assign cfg_if[g].rate_reg = st_q.rate[g];
        assign cfg_if[g].link_reg = st_q.link[g];
        assign cfg_if[g].an_failed = an_failed[g];
        assign cfg_if[g].an_speed_100 = an_speed_100[g];
        assign cfg_if[g].an_full = an_full[g];
        assign cfg_if[g].hi_cnt = hi_cnt[g];
        assign cfg_if[g].lo_cnt = lo_cnt[g];

        ppc_port_cfg u_port (
            .sys_clk(sys_clk),
            .srst(srst),
            .cfg(cfg_if[g])
        );

        assign rx_hi_fc_en[g] = cfg_if[g].rx_hi_fc_en;
        assign rx_all_lo[g] = cfg_if[g].rx_all_lo;
        assign tx_hi_en[g] = cfg_if[g].tx_hi_en;
        assign tx_lo_en[g] = cfg_if[g].tx_lo_en;
        assign tx_hi_rate[g] = cfg_if[g].tx_hi_rate;
        assign tx_lo_rate[g] = cfg_if[g].tx_lo_rate;
        assign an_enable[g] = cfg_if[g].an_enable;
        assign speed_100[g] = cfg_if[g].speed_100;
        assign full_duplex[g] = cfg_if[g].full_duplex;
        assign adv_fc[g] = cfg_if[g].adv_fc;
    end
endmodule : ppc_port_rate_link
`default_nettype wire

/* File: ppc_pkg.sv */
`default_nettype none
package ppc_pkg;
    localparam int NPORTS = 5;
    localparam int RATE_W = 12;
    // Register offsets, one pair per port
    localparam logic [7:0] RATE_OFS [NPORTS] = '{8'h1b, 8'h2b, 8'h3b, 8'h4b, 8'h5b};
    localparam logic [7:0] LINK_OFS [NPORTS] = '{8'h1c, 8'h2c, 8'h3c, 8'h4c, 8'h5c};
    // Rate control register fields
    localparam int RX_DIFF_BIT = 7;
    localparam int RX_HI_FC_BIT = 3;
    localparam int TX_DIFF_BIT = 2;
    localparam int TX_LO_EN_BIT = 1;
    localparam int TX_HI_EN_BIT = 0;
    // Link control register fields
    localparam int AN_DIS_BIT = 7;
    localparam int SPEED_BIT = 6;
    localparam int DUPLEX_BIT = 5;
    localparam int ADV_FC_BIT = 4;
    // Reset values
    localparam logic [7:0] RATE_RST = 8'h00;
    localparam logic [7:0] LINK_RST = 8'h5f;
    localparam logic [7:0] UNMAPPED_RD = 8'h00;
    // Port whose duplex default comes from the strap
    localparam int STRAP_PORT = 3;
    // Cycles after reset release before the synchronised strap is valid
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
endpackage : ppc_pkg
`default_nettype wire

/* File: ppc_cfg_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface ppc_cfg_if;
    import ppc_pkg::*;
    logic [7:0] rate_reg;
    logic [7:0] link_reg;
    logic an_failed;
    logic an_speed_100;
    logic an_full;
    logic [RATE_W-1:0] hi_cnt;
    logic [RATE_W-1:0] lo_cnt;
    logic rx_hi_fc_en;
    logic rx_all_lo;
    logic tx_hi_en;
    logic tx_lo_en;
    logic [RATE_W-1:0] tx_hi_rate;
    logic [RATE_W-1:0] tx_lo_rate;
    logic an_enable;
    logic speed_100;
    logic full_duplex;
    logic adv_fc;
    modport bank (output rate_reg, link_reg, an_failed, an_speed_100, an_full, hi_cnt, lo_cnt,
        input rx_hi_fc_en, rx_all_lo, tx_hi_en, tx_lo_en, tx_hi_rate, tx_lo_rate, an_enable,
        speed_100, full_duplex, adv_fc);
    modport port (input rate_reg, link_reg, an_failed, an_speed_100, an_full, hi_cnt, lo_cnt,
        output rx_hi_fc_en, rx_all_lo, tx_hi_en, tx_lo_en, tx_hi_rate, tx_lo_rate, an_enable,
        speed_100, full_duplex, adv_fc);
endinterface : ppc_cfg_if
`default_nettype wire

/* File: ppc_port_cfg.sv */
`timescale 1ns/10ps
`default_nettype none
module ppc_port_cfg
    import ppc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Port configuration
    ppc_cfg_if.port cfg
);
    typedef struct packed {
        logic rx_hi_fc_en;
        logic rx_all_lo;
        logic tx_hi_en;
        logic tx_lo_en;
        logic [RATE_W-1:0] tx_hi_rate;
        logic [RATE_W-1:0] tx_lo_rate;
        logic an_enable;
        logic speed_100;
        logic full_duplex;
        logic adv_fc;
    } ppc_port_st_t;

    ppc_port_st_t st_q;
    ppc_port_st_t st_d;
    logic rx_diff;
    logic tx_diff;
    logic an_dis;

    assign rx_diff = cfg.rate_reg[RX_DIFF_BIT];
    assign tx_diff = cfg.rate_reg[TX_DIFF_BIT];
    assign an_dis = cfg.link_reg[AN_DIS_BIT];

    // Decode both registers into the controls the port datapath uses
    always_comb
    begin
        st_d = st_q;
        st_d.rx_hi_fc_en = cfg.rate_reg[RX_HI_FC_BIT] & rx_diff;
        st_d.rx_all_lo = ~rx_diff;
        st_d.tx_lo_en = cfg.rate_reg[TX_LO_EN_BIT];
        st_d.tx_hi_en = cfg.rate_reg[TX_HI_EN_BIT] & tx_diff;
        // High-priority packets borrow the low counter unless differential
        st_d.tx_hi_rate = tx_diff ? cfg.hi_cnt : cfg.lo_cnt;
        st_d.tx_lo_rate = cfg.lo_cnt;
        st_d.an_enable = ~an_dis;
        st_d.speed_100 = an_dis ? cfg.link_reg[SPEED_BIT] : cfg.an_speed_100;
        // A failed negotiation falls back to the forced duplex as well
        st_d.full_duplex = (an_dis | cfg.an_failed) ? cfg.link_reg[DUPLEX_BIT]
                                                    : cfg.an_full;
        st_d.adv_fc = cfg.link_reg[ADV_FC_BIT];
        if (srst)
        begin
            st_d = '0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        st_q <= st_d;
    end

    assign cfg.rx_hi_fc_en = st_q.rx_hi_fc_en;
    assign cfg.rx_all_lo = st_q.rx_all_lo;
    assign cfg.tx_hi_en = st_q.tx_hi_en;
    assign cfg.tx_lo_en = st_q.tx_lo_en;
    assign cfg.tx_hi_rate = st_q.tx_hi_rate;
    assign cfg.tx_lo_rate = st_q.tx_lo_rate;
    assign cfg.an_enable = st_q.an_enable;
    assign cfg.speed_100 = st_q.speed_100;
    assign cfg.full_duplex = st_q.full_duplex;
    assign cfg.adv_fc = st_q.adv_fc;
endmodule : ppc_port_cfg
`default_nettype wire

/* File: ppc_link_partner.sv */
`timescale 1ns/10ps
`default_nettype none
module ppc_link_partner
    import ppc_pkg::*;
(
    // Scenario control
    input wire logic [NPORTS-1:0] fail_mask,
    // Negotiation results and rate counts
    output logic [NPORTS-1:0] an_failed,
    output logic [NPORTS-1:0] an_speed_100,
    output logic [NPORTS-1:0] an_full,
    output logic [NPORTS-1:0][RATE_W-1:0] hi_cnt,
    output logic [NPORTS-1:0][RATE_W-1:0] lo_cnt
);
    // Speed and duplex results alternate from port to port, so a swap of adjacent ports shows up
    assign an_failed = fail_mask;
    assign an_speed_100 = 5'h15;
    assign an_full = 5'h0a;
    // Counts carry the port index in their low bits
    always_comb
    begin
        for (int p = 0; p < NPORTS; p++)
        begin
            hi_cnt[p] = 12'ha00 | RATE_W'(p);
            lo_cnt[p] = 12'h500 | RATE_W'(p);
        end
    end
endmodule : ppc_link_partner
`default_nettype wire

/* File: ppc_port_rate_link_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module ppc_port_rate_link_assertions
    import ppc_pkg::*;
(
    // Clock, reset and read side of the bus
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    // Negotiation results
    input wire logic [NPORTS-1:0] an_failed,
    input wire logic [NPORTS-1:0] an_speed_100,
    input wire logic [NPORTS-1:0] an_full,
    // Per-port controls
    input wire logic [NPORTS-1:0] rx_hi_fc_en,
    input wire logic [NPORTS-1:0] rx_all_lo,
    input wire logic [NPORTS-1:0] an_enable,
    input wire logic [NPORTS-1:0] speed_100,
    input wire logic [NPORTS-1:0] full_duplex
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    // Outputs lag the registers by one edge, so skip the edge right after reset
    a_fc_needs_diff: assert property ((rx_hi_fc_en & rx_all_lo) == '0)
        else $error("high flow control without differential receive");
    a_rd_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    a_rd_quiet: assert property (!reg_rd |=> !reg_rvalid && reg_rdata == 8'h00)
        else $error("read data without a read");
    a_rst_clear: assert property ($past(srst) |-> an_enable == '0 && rx_all_lo == '0)
        else $error("controls not cleared by reset");
    a_an_default: assert property ($past(srst, 2) && !$past(srst) |-> an_enable == '1)
        else $error("negotiation off after reset");
    a_rx_default: assert property ($past(srst, 2) && !$past(srst) |-> rx_all_lo == '1)
        else $error("receive not on low rate after reset");
    a_speed_auto: assert property (!$past(srst) |->
        ((speed_100 ^ $past(an_speed_100)) & an_enable) == '0)
        else $error("speed not from negotiation");
    a_duplex_auto: assert property (!$past(srst) |->
        ((full_duplex ^ $past(an_full)) & an_enable & ~$past(an_failed)) == '0)
        else $error("duplex not from negotiation");
endmodule : ppc_port_rate_link_assertions
`default_nettype wire

/* File: tb_ppc_port_rate_link.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_ppc_port_rate_link;
    import ppc_pkg::*;
    localparam logic [7:0] RATE_SET [NPORTS] = '{8'h8f, 8'h0b, 8'h05, 8'h02, 8'h00};
    localparam logic [7:0] LINK_SET [NPORTS] = '{8'hc0, 8'h80, 8'h20, 8'h00, 8'hb0};
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic duplex_strap_pin = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic [NPORTS-1:0] fail_mask = '0;
    logic [NPORTS-1:0] an_failed, an_speed_100, an_full, rx_hi_fc_en, rx_all_lo;
    logic [NPORTS-1:0] tx_hi_en, tx_lo_en, an_enable, speed_100, full_duplex, adv_fc;
    logic [NPORTS-1:0][RATE_W-1:0] hi_cnt, lo_cnt, tx_hi_rate, tx_lo_rate;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    ppc_port_rate_link ppc_port_rate_link_i (
        .sys_clk(sys_clk),
        .srst(srst),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid),
        .duplex_strap_pin(duplex_strap_pin),
        .an_failed(an_failed),
        .an_speed_100(an_speed_100),
        .an_full(an_full),
        .hi_cnt(hi_cnt),
        .lo_cnt(lo_cnt),
        .rx_hi_fc_en(rx_hi_fc_en),
        .rx_all_lo(rx_all_lo),
        .tx_hi_en(tx_hi_en),
        .tx_lo_en(tx_lo_en),
        .tx_hi_rate(tx_hi_rate),
        .tx_lo_rate(tx_lo_rate),
        .an_enable(an_enable),
        .speed_100(speed_100),
        .full_duplex(full_duplex),
        .adv_fc(adv_fc)
    );
    ppc_link_partner ppc_link_partner_i (
        .fail_mask(fail_mask),
        .an_failed(an_failed),
        .an_speed_100(an_speed_100),
        .an_full(an_full),
        .hi_cnt(hi_cnt),
        .lo_cnt(lo_cnt)
    );
    // Clock and hang guard
    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            miscompares++;
            end_sim();
        end
    end
    task automatic end_sim();
        if (miscompares == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // One-cycle strobes, held from one edge to the next
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, e});
        chk("reg_rvalid", reg_rvalid, 1'b1);
    endtask : rd
    // Reset with a given strap level, then check every register default
    task automatic t_reset(input logic s, input logic [7:0] e);
        @(posedge sys_clk);
        srst <= 1'b1;
        duplex_strap_pin <= s;
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (6) @(posedge sys_clk);
        #1;
        chk("an_enable", an_enable, 5'h1f);
        chk("adv_fc", adv_fc, 5'h1f);
        for (int p = 0; p < NPORTS; p++)
        begin
            rd(RATE_OFS[p], RATE_RST);
            rd(LINK_OFS[p], p == STRAP_PORT ? e : LINK_RST);
        end
    endtask : t_reset
    // A different rate setting on each port
    task automatic t_rate();
        for (int p = 0; p < NPORTS; p++)
            wr(RATE_OFS[p], RATE_SET[p]);
        repeat (2) @(posedge sys_clk);
        #1;
        chk("rx_hi_fc_en", rx_hi_fc_en, 5'h01);
        chk("rx_all_lo", rx_all_lo, 5'h1e);
        chk("tx_hi_en", tx_hi_en, 5'h05);
        chk("tx_lo_en", tx_lo_en, 5'h0b);
        chk("tx_hi_rate0", tx_hi_rate[0], 12'ha00);
        chk("tx_hi_rate1", tx_hi_rate[1], 12'h501);
        chk("tx_lo_rate2", tx_lo_rate[2], 12'h502);
    endtask : t_rate
    // Forced and negotiated links side by side, port 2 failing negotiation
    task automatic t_link();
        @(posedge sys_clk);
        fail_mask <= 5'h04;
        for (int p = 0; p < NPORTS; p++)
            wr(LINK_OFS[p], LINK_SET[p]);
        repeat (2) @(posedge sys_clk);
        #1;
        chk("an_enable", an_enable, 5'h0c);
        chk("speed_100", speed_100, 5'h05);
        chk("full_duplex", full_duplex, 5'h1c);
        chk("adv_fc", adv_fc, 5'h10);
        wr(8'h1d, 8'hff);
        rd(8'h1d, 8'h00);
        rd(LINK_OFS[0], 8'hc0);
        rd(LINK_OFS[4], 8'hb0);
    endtask : t_link
    initial
    begin
        t_reset(1'b1, 8'h7f);
        t_rate();
        t_link();
        t_reset(1'b0, LINK_RST);
        end_sim();
    end
endmodule : tb_ppc_port_rate_link
bind ppc_port_rate_link ppc_port_rate_link_assertions ppc_port_rate_link_assertions_i (
    .sys_clk(sys_clk),
    .srst(srst),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .an_failed(an_failed),
    .an_speed_100(an_speed_100),
    .an_full(an_full),
    .rx_hi_fc_en(rx_hi_fc_en),
    .rx_all_lo(rx_all_lo),
    .an_enable(an_enable),
    .speed_100(speed_100),
    .full_duplex(full_duplex)
);
`default_nettype wire
